// >>> rtl/cod_pkg.sv
// cod_pkg: opcode patterns, field positions and reset values of the control-op decoder
// assumes: 16-bit instruction words presented by the fetch stage
package cod_pkg;

  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned MODE_POS = 7;
  localparam int unsigned BITSEL_HI = 11;
  localparam int unsigned BITSEL_LO = 8;
  localparam int unsigned CFG_W = 2;

  // top-byte opcodes, and the top nibble of the fixed bit test
  localparam logic [7:0] OP_TEST_BIT_BY_TEMP = 8'h57;
  localparam logic [7:0] OP_LOAD_STATUS_ZERO = 8'h50;
  localparam logic [7:0] OP_LOAD_STATUS_ONE = 8'h51;
  localparam logic [7:0] OP_STORE_STATUS_ZERO = 8'h78;
  localparam logic [7:0] OP_STORE_STATUS_ONE = 8'h79;
  localparam logic [7:0] OP_POP_TO_MEMORY = 8'h7a;
  localparam logic [7:0] OP_PUSH_FROM_MEMORY = 8'h54;
  localparam logic [7:0] OP_REPEAT_FROM_MEMORY = 8'h4b;
  localparam logic [7:0] OP_REPEAT_IMMEDIATE = 8'hcb;
  localparam logic [3:0] OP_TEST_BIT_NIBBLE = 4'h9;

  // block configuration: upper fourteen bits fixed, two low bits the field
  localparam logic [15:0] OP_RAM_BLOCK_CONFIG = 16'hce3c;
  localparam logic [15:0] CFG_MASK = 16'hfffc;

  // fixed words
  localparam logic [15:0] OP_POP_ACC = 16'hce1d;
  localparam logic [15:0] OP_PUSH_ACC = 16'hce1c;
  localparam logic [15:0] OP_CLEAR_CARRY = 16'hce30;
  localparam logic [15:0] OP_SET_CARRY = 16'hce31;
  localparam logic [15:0] OP_CLEAR_HOLD_MODE = 16'hce38;
  localparam logic [15:0] OP_SET_HOLD_MODE = 16'hce39;
  localparam logic [15:0] OP_CLEAR_OVERFLOW_MODE = 16'hce02;
  localparam logic [15:0] OP_SET_OVERFLOW_MODE = 16'hce03;
  localparam logic [15:0] OP_CLEAR_SIGN_EXT = 16'hce06;
  localparam logic [15:0] OP_SET_SIGN_EXT = 16'hce07;
  localparam logic [15:0] OP_CLEAR_TEST_FLAG = 16'hce32;
  localparam logic [15:0] OP_SET_TEST_FLAG = 16'hce33;
  localparam logic [15:0] OP_INTERRUPT_DISABLE = 16'hce01;
  localparam logic [15:0] OP_INTERRUPT_ENABLE = 16'hce00;
  localparam logic [15:0] OP_IDLE = 16'hce1f;
  localparam logic [15:0] OP_SOFT_TRAP = 16'hce1e;
  localparam logic [15:0] OP_NO_OP = 16'h5500;

  // flag indices inside the flag vector
  localparam int unsigned FL_CARRY = 0;
  localparam int unsigned FL_HOLD = 1;
  localparam int unsigned FL_OVM = 2;
  localparam int unsigned FL_SXM = 3;
  localparam int unsigned FL_TC = 4;
  localparam int unsigned FL_INTM = 5;
  localparam int unsigned FL_N = 6;

  // reset values of the held state
  localparam logic [6:0] FLAGS_RST = 7'h22;
  localparam logic [1:0] CFG_RST = 2'h0;

  // decoded operation classes
  typedef enum logic [4:0] {
    COD_NONE = 5'h00, COD_TBT = 5'h01, COD_TBIT = 5'h02, COD_CFG = 5'h03,
    COD_LDS0 = 5'h04, COD_LDS1 = 5'h05, COD_STS0 = 5'h06, COD_STS1 = 5'h07,
    COD_POPA = 5'h08, COD_PUSHA = 5'h09, COD_POPM = 5'h0a, COD_PUSHM = 5'h0b,
    COD_REPM = 5'h0c, COD_REPK = 5'h0d, COD_FLAG = 5'h0e, COD_IOFF = 5'h0f,
    COD_ION = 5'h10, COD_IDLE = 5'h11, COD_TRAP = 5'h12, COD_NOP = 5'h13
  } cod_op_e;

  typedef enum logic [1:0] {
    COD_RUN = 2'b01,
    COD_IDLING = 2'b10
  } cod_state_e;

endpackage : cod_pkg

// >>> rtl/cod_classify.sv
// cod_classify: pure combinational opcode classifier
// assumes: word is stable for the cycle it is classified in
`timescale 1ns/10ps
module cod_classify
  import cod_pkg::*;
(
  input wire logic [WORD_W-1:0] word, // instruction word
  output cod_op_e op, // decoded class
  output logic [2:0] flag_sel, // which flag a set/clear op hits
  output logic flag_val // value written by that op
);

  always_comb begin
    op = COD_NONE;
    flag_sel = 3'h0;
    flag_val = 1'b0;
    if (word[15:12] == OP_TEST_BIT_NIBBLE) begin
      op = COD_TBIT;
    end else if ((word & CFG_MASK) == OP_RAM_BLOCK_CONFIG) begin
      op = COD_CFG;
    end else begin
      unique case (word[15:8])
        OP_TEST_BIT_BY_TEMP: op = COD_TBT;
        OP_LOAD_STATUS_ZERO: op = COD_LDS0;
        OP_LOAD_STATUS_ONE: op = COD_LDS1;
        OP_STORE_STATUS_ZERO: op = COD_STS0;
        OP_STORE_STATUS_ONE: op = COD_STS1;
        OP_POP_TO_MEMORY: op = COD_POPM;
        OP_PUSH_FROM_MEMORY: op = COD_PUSHM;
        OP_REPEAT_FROM_MEMORY: op = COD_REPM;
        OP_REPEAT_IMMEDIATE: op = COD_REPK;
        default: op = COD_NONE;
      endcase
      unique case (word)
        OP_POP_ACC: op = COD_POPA;
        OP_PUSH_ACC: op = COD_PUSHA;
        OP_INTERRUPT_DISABLE: op = COD_IOFF;
        OP_INTERRUPT_ENABLE: op = COD_ION;
        OP_IDLE: op = COD_IDLE;
        OP_SOFT_TRAP: op = COD_TRAP;
        OP_NO_OP: op = COD_NOP;
        OP_CLEAR_CARRY, OP_SET_CARRY: begin
          op = COD_FLAG;
          flag_sel = 3'(FL_CARRY);
          flag_val = word[0];
        end
        OP_CLEAR_HOLD_MODE, OP_SET_HOLD_MODE: begin
          op = COD_FLAG;
          flag_sel = 3'(FL_HOLD);
          flag_val = word[0];
        end
        OP_CLEAR_OVERFLOW_MODE, OP_SET_OVERFLOW_MODE: begin
          op = COD_FLAG;
          flag_sel = 3'(FL_OVM);
          flag_val = word[0];
        end
        OP_CLEAR_SIGN_EXT, OP_SET_SIGN_EXT: begin
          op = COD_FLAG;
          flag_sel = 3'(FL_SXM);
          flag_val = word[0];
        end
        OP_CLEAR_TEST_FLAG, OP_SET_TEST_FLAG: begin
          op = COD_FLAG;
          flag_sel = 3'(FL_TC);
          flag_val = word[0];
        end
        default: begin
        end
      endcase
    end
  end

endmodule : cod_classify

// >>> rtl/cod_field.sv
// cod_field: splits the operand fields of a word
// assumes: caller qualifies the fields with the decoded class
`timescale 1ns/10ps
module cod_field
  import cod_pkg::*;
(
  input wire logic [WORD_W-1:0] word, // instruction word
  output logic mode, // indirect addressing mode bit
  output logic [ADDR_W-1:0] addr, // direct operand address
  output logic [3:0] bit_sel, // bit number for the bit test
  output logic [7:0] imm, // immediate count
  output logic [CFG_W-1:0] cfg // block configuration field
);

  assign mode = word[MODE_POS];
  assign addr = word[ADDR_W-1:0];
  assign bit_sel = word[BITSEL_HI:BITSEL_LO];
  assign imm = word[7:0];
  assign cfg = word[CFG_W-1:0];

endmodule : cod_field

// >>> rtl/cod_decoder.sv
// cod_decoder: control-instruction decoder of the fixed-point core
// assumes: one word per cycle with instr_valid; core stalls the fetch while busy is high
//
// How it works
// - 0x57xx tests data bit chosen by temp
// - 0xCE3C masked sets RAM block configuration
// - 0x50xx loads status word zero
// - 0x51xx loads status word one
// - 0x78xx stores status word zero
// - 0x79xx stores status word one
// - 0xCE1D pops stack into low accumulator
// - 0xCE1C pushes low accumulator onto stack
// - 0x7Axx pops stack into data memory
// - 0x54xx pushes data memory onto stack
// - 0x4Bxx loads repeat count from memory
// - 0xCBxx repeats next with immediate count
`timescale 1ns/10ps
module cod_decoder
  import cod_pkg::*;
(
  input wire logic clk, // core clock, 40 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic instr_valid, // instr word valid this cycle
  input wire logic [WORD_W-1:0] instr, // instruction word
  input wire logic irq_pending, // any enabled interrupt waiting
  input wire logic rep_load_valid, // repeat count read back from memory
  input wire logic [7:0] rep_load_val, // that count
  input wire logic st_load_valid, // status word read back for a load
  input wire logic [6:0] st_load_val, // its flag bits
  output logic busy, // decoder not ready for a new word
  output logic mem_rd, // data memory read request pulse
  output logic mem_wr, // data memory write request pulse
  output logic mem_mode, // indirect addressing mode
  output logic [ADDR_W-1:0] mem_addr, // direct operand address
  output logic [WORD_W-1:0] mem_wdata, // data for a status store
  output logic stk_push, // push pulse to hardware stack
  output logic stk_pop, // pop pulse from hardware stack
  output logic stk_acc, // stack op moves the low accumulator
  output logic acc_from_stk, // pop lands in low accumulator
  output logic bit_test, // bit test pulse
  output logic bit_by_temp, // bit number comes from temp register
  output logic [3:0] bit_num, // bit number for a fixed test
  output logic rep_active, // next instruction is repeated
  output logic [7:0] rep_count, // repeat count
  output logic [CFG_W-1:0] block_config_field, // RAM block setting
  output logic [6:0] flags, // carry, hold, ovm, sxm, tc, intm, spare
  output logic trap, // software trap pulse
  output logic idle, // idling until interrupt
  output logic nop_seen // no-op retired pulse
);

  ////////////////////////////////////////////////////////////////////////
  // decode
  cod_op_e op;
  logic [2:0] flag_sel;
  logic flag_val;
  logic f_mode;
  logic [ADDR_W-1:0] f_addr;
  logic [3:0] f_bit;
  logic [7:0] f_imm;
  logic [CFG_W-1:0] f_cfg;

  cod_classify u_cls (
    .word(instr),
    .op(op),
    .flag_sel(flag_sel),
    .flag_val(flag_val)
  );

  cod_field u_fld (
    .word(instr),
    .mode(f_mode),
    .addr(f_addr),
    .bit_sel(f_bit),
    .imm(f_imm),
    .cfg(f_cfg)
  );

  ////////////////////////////////////////////////////////////////////////
  // state
  cod_state_e st_q, st_d;
  logic take;
  logic wait_rep_q, wait_rep_d;
  logic wait_st_q, wait_st_d;
  logic mem_rd_q, mem_rd_d, mem_wr_q, mem_wr_d, mode_q, mode_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [WORD_W-1:0] wdata_q, wdata_d;
  logic push_q, push_d, pop_q, pop_d, sacc_q, sacc_d, afs_q, afs_d;
  logic bt_q, bt_d, btt_q, btt_d;
  logic [3:0] bn_q, bn_d;
  logic ra_q, ra_d;
  logic [7:0] rn_q, rn_d;
  logic [CFG_W-1:0] cfg_q, cfg_d;
  logic [6:0] fl_q, fl_d;
  logic trap_q, trap_d, nop_q, nop_d;

  // status layout: status word zero carries ovm/intm, one carries all seven flags
  function automatic logic [WORD_W-1:0] pack_status(input logic [6:0] f, input logic one);
    pack_status = one ? {9'h000, f} : {9'h000, 1'b0, f[FL_INTM], 2'b00, f[FL_OVM], 2'b00};
  endfunction : pack_status

  // a waiting memory read blocks new words so the fetch cannot overrun it
  assign take = instr_valid && st_q == COD_RUN && !wait_rep_q && !wait_st_q;

  always_comb begin
    st_d = st_q;
    wait_rep_d = wait_rep_q;
    wait_st_d = wait_st_q;
    mem_rd_d = 1'b0;
    mem_wr_d = 1'b0;
    mode_d = mode_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    push_d = 1'b0;
    pop_d = 1'b0;
    sacc_d = 1'b0;
    afs_d = 1'b0;
    bt_d = 1'b0;
    btt_d = 1'b0;
    bn_d = bn_q;
    ra_d = ra_q;
    rn_d = rn_q;
    cfg_d = cfg_q;
    fl_d = fl_q;
    trap_d = 1'b0;
    nop_d = 1'b0;
    if (wait_rep_q && rep_load_valid) begin
      wait_rep_d = 1'b0;
      ra_d = 1'b1;
      rn_d = rep_load_val;
    end
    if (wait_st_q && st_load_valid) begin
      wait_st_d = 1'b0;
      fl_d = st_load_val;
    end
    unique case (st_q)
      COD_IDLING: begin
        if (irq_pending) begin
          st_d = COD_RUN;
        end
      end
      COD_RUN: begin
        if (take) begin
          if (ra_q && op != COD_REPK && op != COD_REPM) begin
            ra_d = rn_q != 8'h00;
            rn_d = rn_q - 8'h01;
          end
          mode_d = f_mode;
          addr_d = f_addr;
          unique case (op)
            COD_TBT: begin
              bt_d = 1'b1;
              btt_d = 1'b1;
              mem_rd_d = 1'b1;
            end
            COD_TBIT: begin
              bt_d = 1'b1;
              bn_d = f_bit;
              mem_rd_d = 1'b1;
            end
            COD_CFG: cfg_d = f_cfg;
            COD_LDS0, COD_LDS1: begin
              mem_rd_d = 1'b1;
              wait_st_d = 1'b1;
            end
            COD_STS0, COD_STS1: begin
              mem_wr_d = 1'b1;
              wdata_d = pack_status(fl_q, op == COD_STS1);
            end
            COD_POPA: begin
              pop_d = 1'b1;
              sacc_d = 1'b1;
              afs_d = 1'b1;
            end
            COD_PUSHA: begin
              push_d = 1'b1;
              sacc_d = 1'b1;
            end
            COD_POPM: begin
              pop_d = 1'b1;
              mem_wr_d = 1'b1;
            end
            COD_PUSHM: begin
              push_d = 1'b1;
              mem_rd_d = 1'b1;
            end
            COD_REPM: begin
              mem_rd_d = 1'b1;
              wait_rep_d = 1'b1;
            end
            COD_REPK: begin
              ra_d = 1'b1;
              rn_d = f_imm;
            end
            COD_FLAG: fl_d[flag_sel] = flag_val;
            COD_IOFF: fl_d[FL_INTM] = 1'b1;
            COD_ION: fl_d[FL_INTM] = 1'b0;
            COD_IDLE: st_d = COD_IDLING;
            COD_TRAP: trap_d = 1'b1;
            COD_NOP: nop_d = 1'b1;
            default: begin
            end
          endcase
        end
      end
      default: st_d = COD_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= COD_RUN;
      wait_rep_q <= 1'b0;
      wait_st_q <= 1'b0;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mode_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
      push_q <= 1'b0;
      pop_q <= 1'b0;
      sacc_q <= 1'b0;
      afs_q <= 1'b0;
      bt_q <= 1'b0;
      btt_q <= 1'b0;
      bn_q <= 4'h0;
      ra_q <= 1'b0;
      rn_q <= 8'h00;
      cfg_q <= CFG_RST;
      fl_q <= FLAGS_RST;
      trap_q <= 1'b0;
      nop_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      wait_rep_q <= wait_rep_d;
      wait_st_q <= wait_st_d;
      mem_rd_q <= mem_rd_d;
      mem_wr_q <= mem_wr_d;
      mode_q <= mode_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      push_q <= push_d;
      pop_q <= pop_d;
      sacc_q <= sacc_d;
      afs_q <= afs_d;
      bt_q <= bt_d;
      btt_q <= btt_d;
      bn_q <= bn_d;
      ra_q <= ra_d;
      rn_q <= rn_d;
      cfg_q <= cfg_d;
      fl_q <= fl_d;
      trap_q <= trap_d;
      nop_q <= nop_d;
    end
  end

  // busy and idle get their own flops so the outputs come straight from registers
  logic busy_q;
  logic idle_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      idle_q <= 1'b0;
    end else if (ce) begin
      busy_q <= st_d == COD_IDLING || wait_rep_d || wait_st_d;
      idle_q <= st_d == COD_IDLING;
    end
  end

  assign busy = busy_q;
  assign mem_rd = mem_rd_q;
  assign mem_wr = mem_wr_q;
  assign mem_mode = mode_q;
  assign mem_addr = addr_q;
  assign mem_wdata = wdata_q;
  assign stk_push = push_q;
  assign stk_pop = pop_q;
  assign stk_acc = sacc_q;
  assign acc_from_stk = afs_q;
  assign bit_test = bt_q;
  assign bit_by_temp = btt_q;
  assign bit_num = bn_q;
  assign rep_active = ra_q;
  assign rep_count = rn_q;
  assign block_config_field = cfg_q;
  assign flags = fl_q;
  assign trap = trap_q;
  assign idle = idle_q;
  assign nop_seen = nop_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_cfg_field: assert property (take && ce && op == COD_CFG |=> cfg_q == $past(instr[1:0]))
    else $error("block config not taken");
  a_tbt_read: assert property (take && ce && op == COD_TBT |=> bt_q && btt_q && mem_rd_q)
    else $error("temp bit test missing");
  a_load_wait: assert property (take && ce && op == COD_LDS0 |=> wait_st_q && busy_q)
    else $error("status load not waiting");
  a_store_wr: assert property (take && ce && op == COD_STS1 |=> mem_wr_q && !mem_rd_q)
    else $error("status store missing");
  a_pop_acc: assert property (take && ce && instr == OP_POP_ACC |=> pop_q && afs_q)
    else $error("pop to acc missing");
  a_push_acc: assert property (take && ce && instr == OP_PUSH_ACC |=> push_q && !pop_q)
    else $error("push acc missing");
  a_imm_repeat: assert property (take && ce && op == COD_REPK |=> ra_q && rn_q == $past(f_imm))
    else $error("immediate repeat wrong");
  a_carry_set: assert property (take && ce && instr == OP_SET_CARRY |=> fl_q[FL_CARRY])
    else $error("carry not set");
  a_intm_dis: assert property (take && ce && instr == OP_INTERRUPT_DISABLE |=> fl_q[FL_INTM])
    else $error("interrupts not disabled");
  a_pushm_read: assert property (take && ce && op == COD_PUSHM |=> push_q && mem_rd_q)
    else $error("push from memory missing");

  c_idle_wake: cover property (idle ##[1:20] !idle);
  c_rep_mem: cover property (wait_rep_q ##1 ra_q);
  c_trap: cover property (trap_q);

endmodule : cod_decoder

// >>> sim/cod_mem_model.sv
// cod_mem_model: data memory on the far side of the decoder, answers read requests
// assumes: bench picks which read-back strobe answers and the latency; lat 0 means no answer
`timescale 1ns/10ps
module cod_mem_model (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic mem_rd, // read request pulse
  input wire logic mem_wr, // write request pulse
  input wire logic [6:0] mem_addr, // operand address
  input wire logic [15:0] mem_wdata, // write data
  input wire logic rep_sel, // answer on the repeat strobe
  input wire logic [3:0] lat, // cycles from request to answer
  output logic st_load_valid, // status read-back pulse
  output logic [6:0] st_load_val, // status read-back value
  output logic rep_load_valid, // count read-back pulse
  output logic [7:0] rep_load_val // count read-back value
);
  logic [15:0] mem [128];
  logic [3:0] cnt_q;
  logic [6:0] ra_q;

  // lines off a read-back show the inverse of their last value, never a stale copy
  // one process owns the array; reset reloads the index pattern
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 128; i++) begin
        mem[i] <= 16'(i);
      end
      cnt_q <= 4'h0;
      ra_q <= 7'h00;
      st_load_valid <= 1'b0;
      rep_load_valid <= 1'b0;
      st_load_val <= 7'h00;
      rep_load_val <= 8'h00;
    end else begin
      st_load_valid <= 1'b0;
      rep_load_valid <= 1'b0;
      st_load_val <= ~st_load_val;
      rep_load_val <= ~rep_load_val;
      if (mem_wr) begin
        mem[mem_addr] <= mem_wdata;
      end
      if (mem_rd) begin
        cnt_q <= lat;
        ra_q <= mem_addr;
      end else if (cnt_q == 4'h1) begin
        cnt_q <= 4'h0;
        if (rep_sel) begin
          rep_load_valid <= 1'b1;
          rep_load_val <= mem[ra_q][7:0];
        end else begin
          st_load_valid <= 1'b1;
          st_load_val <= mem[ra_q][6:0];
        end
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule : cod_mem_model

// >>> sim/test_cod_decoder.sv
// test_cod_decoder: self-checking bench of the control-op decoder
// assumes: cod_pkg compiled first; memory model answers read-backs
`timescale 1ns/10ps
module test_cod_decoder;
  import cod_pkg::*;
  logic clk, rst_n, ce, instr_valid, irq_pending, rep_sel;
  logic [15:0] instr, mem_wdata;
  logic [3:0] lat, bit_num;
  logic rep_load_valid, st_load_valid, busy, mem_rd, mem_wr, mem_mode, stk_push, stk_pop;
  logic stk_acc, acc_from_stk, bit_test, bit_by_temp, rep_active, trap, idle, nop_seen;
  logic [7:0] rep_load_val, rep_count;
  logic [6:0] st_load_val, mem_addr, flags, expf;
  logic [1:0] block_config_field;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;

  cod_decoder cod_decoder_i (.clk(clk), .rst_n(rst_n), .ce(ce), .instr_valid(instr_valid),
    .instr(instr), .irq_pending(irq_pending), .rep_load_valid(rep_load_valid),
    .rep_load_val(rep_load_val), .st_load_valid(st_load_valid), .st_load_val(st_load_val),
    .busy(busy), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_mode(mem_mode), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .stk_push(stk_push), .stk_pop(stk_pop), .stk_acc(stk_acc),
    .acc_from_stk(acc_from_stk), .bit_test(bit_test), .bit_by_temp(bit_by_temp),
    .bit_num(bit_num), .rep_active(rep_active), .rep_count(rep_count),
    .block_config_field(block_config_field), .flags(flags), .trap(trap), .idle(idle),
    .nop_seen(nop_seen));

  cod_mem_model cod_mem_model_i (.clk(clk), .rst_n(rst_n), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .rep_sel(rep_sel), .lat(lat),
    .st_load_valid(st_load_valid), .st_load_val(st_load_val),
    .rep_load_valid(rep_load_valid), .rep_load_val(rep_load_val));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  // whole run is under two hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up;
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // word taken at the second edge; outputs looked at just after it
  task automatic issue(input logic [15:0] w);
    @(posedge clk);
    instr <= w;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask : issue

  task automatic wait_rsp(input logic rep);
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if ((rep ? rep_load_valid : st_load_valid) === 1'b1) break;
    end
    if (n == 20) chk("read_back", 16'h0001, 16'h0000);
    #1;
  endtask : wait_rsp

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    #1;
    chk("flags", 16'h0022, flags);
    chk("cfg", 16'h0000, block_config_field);
    chk("busy", 16'h0000, busy);
    chk("idle", 16'h0000, idle);
    chk("rep_active", 16'h0000, rep_active);
    expf = 7'h22;
    $display("test reset done");
  endtask : t_reset

  task automatic t_flags;
    logic [15:0] fw [12];
    int b;
    fw = '{OP_SET_CARRY, OP_CLEAR_CARRY, OP_SET_HOLD_MODE, OP_CLEAR_HOLD_MODE,
      OP_SET_OVERFLOW_MODE, OP_CLEAR_OVERFLOW_MODE, OP_SET_SIGN_EXT, OP_CLEAR_SIGN_EXT,
      OP_SET_TEST_FLAG, OP_CLEAR_TEST_FLAG, OP_INTERRUPT_ENABLE, OP_INTERRUPT_DISABLE};
    for (int i = 0; i < 12; i++) begin
      b = i / 2;
      expf[b] = (i < 10) ? (i % 2 == 0) : (i % 2 == 1);
      issue(fw[i]);
      chk("flags", expf, flags);
    end
    issue(16'hce05);
    chk("flags", expf, flags);
    @(posedge clk) ce <= 1'b0;
    issue(OP_SET_CARRY);
    chk("flags", expf, flags);
    @(posedge clk) ce <= 1'b1;
    $display("test flags done");
  endtask : t_flags

  task automatic t_config;
    for (int k = 0; k < 4; k++) begin
      issue(16'hce3c | 16'(k));
      chk("cfg", 16'(k), block_config_field);
    end
    issue(16'hce3b);
    chk("cfg", 16'h0003, block_config_field);
    $display("test config done");
  endtask : t_config

  task automatic t_stack;
    issue(OP_POP_ACC);
    chk("stk_pop", 16'h0001, stk_pop);
    chk("acc_from_stk", 16'h0001, acc_from_stk);
    issue(OP_PUSH_ACC);
    chk("stk_push", 16'h0001, stk_push);
    chk("stk_acc", 16'h0001, stk_acc);
    issue(16'h7a85);
    chk("stk_pop", 16'h0001, stk_pop);
    chk("acc_from_stk", 16'h0000, acc_from_stk);
    chk("addr", 16'h0085, {mem_mode, mem_addr});
    issue(16'h5403);
    chk("stk_push", 16'h0001, stk_push);
    chk("stk_acc", 16'h0000, stk_acc);
    chk("addr", 16'h0003, {mem_mode, mem_addr});
    $display("test stack done");
  endtask : t_stack

  task automatic t_bits;
    issue(16'h9a83);
    chk("bit_test", 16'h0001, bit_test);
    chk("bit_by_temp", 16'h0000, bit_by_temp);
    chk("bit_num", 16'h000a, bit_num);
    chk("addr", 16'h0083, {mem_mode, mem_addr});
    issue(16'h5705);
    chk("bit_test", 16'h0001, bit_test);
    chk("bit_by_temp", 16'h0001, bit_by_temp);
    chk("addr", 16'h0005, {mem_mode, mem_addr});
    $display("test bits done");
  endtask : t_bits

  task automatic t_status;
    issue(16'h7990);
    chk("mem_wr", 16'h0001, mem_wr);
    chk("addr", 16'h0090, {mem_mode, mem_addr});
    chk("wdata", expf, mem_wdata[6:0]);
    issue(16'h7811);
    chk("mem_wr", 16'h0001, mem_wr);
    chk("addr", 16'h0011, {mem_mode, mem_addr});
    chk("wdata", {expf[5], expf[2]}, {mem_wdata[5], mem_wdata[2]});
    issue(OP_SET_CARRY);
    lat <= 4'h4;
    issue(16'h5190);
    chk("mem_rd", 16'h0001, mem_rd);
    chk("busy", 16'h0001, busy);
    chk("addr", 16'h0090, {mem_mode, mem_addr});
    issue(OP_SET_SIGN_EXT);
    chk("flags", expf | 7'h01, flags);
    wait_rsp(1'b0);
    chk("flags", expf, flags);
    chk("busy", 16'h0000, busy);
    lat <= 4'h1;
    issue(16'h5020);
    chk("mem_rd", 16'h0001, mem_rd);
    chk("addr", 16'h0020, {mem_mode, mem_addr});
    wait_rsp(1'b0);
    chk("flags", 16'h0020, flags);
    lat <= 4'h0;
    $display("test status done");
  endtask : t_status

  task automatic t_repeat;
    issue(16'hcb02);
    chk("rep_active", 16'h0001, rep_active);
    chk("rep_count", 16'h0002, rep_count);
    for (int n = 1; n >= 0; n--) begin
      issue(OP_NO_OP);
      chk("nop_seen", 16'h0001, nop_seen);
      chk("rep_count", 16'(n), rep_count);
      chk("rep_active", 16'h0001, rep_active);
    end
    issue(OP_NO_OP);
    chk("rep_active", 16'h0000, rep_active);
    rep_sel <= 1'b1;
    lat <= 4'h2;
    issue(16'h4b07);
    chk("mem_rd", 16'h0001, mem_rd);
    chk("busy", 16'h0001, busy);
    chk("addr", 16'h0007, {mem_mode, mem_addr});
    wait_rsp(1'b1);
    chk("rep_count", 16'h0007, rep_count);
    chk("rep_active", 16'h0001, rep_active);
    chk("busy", 16'h0000, busy);
    lat <= 4'h0;
    $display("test repeat done");
  endtask : t_repeat

  task automatic t_idle;
    issue(OP_SOFT_TRAP);
    chk("trap", 16'h0001, trap);
    @(posedge clk);
    #1;
    chk("trap", 16'h0000, trap);
    issue(OP_IDLE);
    chk("idle", 16'h0001, idle);
    chk("busy", 16'h0001, busy);
    repeat (3) @(posedge clk);
    #1;
    chk("idle", 16'h0001, idle);
    @(posedge clk) irq_pending <= 1'b1;
    @(posedge clk);
    #1;
    chk("idle", 16'h0000, idle);
    chk("busy", 16'h0000, busy);
    @(posedge clk) irq_pending <= 1'b0;
    $display("test idle done");
  endtask : t_idle

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    instr_valid = 1'b0;
    instr = 16'h0000;
    irq_pending = 1'b0;
    rep_sel = 1'b0;
    lat = 4'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_flags;
    t_config;
    t_stack;
    t_bits;
    t_status;
    t_repeat;
    t_idle;
    wrap_up;
  end
endmodule : test_cod_decoder
